/* File: rtl/dmcs_channel_select.sv */
// two upstream masters, their control registers and downstream channel select
// assumes recovery pulses come from a generator on mclk; pins are open drain
`default_nettype none

// How it works
// - one control register per upstream master
// - pointer value 01 selects control register
// - bit 0 is own select
// - bit 1 mirrors peer select bit, inverted in B's view
// - bits 2/3 own and peer connect
// - equal select bits route to channel A
// - differing connect bits connect downstream
// - bit 4 requests downstream bus recovery
// - bit 6 pulls own interrupt low
// - bit 7 pulls peer interrupt low
// - bit 5 always reads zero
// - only writer's STOP updates connection, save first A STOP in delayed variant
// - last writer before STOP wins
// - auto increment writes both registers
// - reset values depend on start-up variant
// - write lands on ninth SCL rise
// - switch only after recovery completes
// - clearing test bit releases interrupt

module dmcs_channel_select
	import dmcs_pkg::*;
#(
	parameter logic [1:0] VARIANT = VARIANT_CONNECTED
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       linkClk,
	input  wire logic       sclA,
	input  wire logic       sdaAIn,
	output logic            sdaAOut,
	output logic            sdaAOe,
	input  wire logic       sclB,
	input  wire logic       sdaBIn,
	output logic            sdaBOut,
	output logic            sdaBOe,
	input  wire logic [3:0] addrPin,
	output logic            intAOut,
	output logic            intAOe,
	output logic            intBOut,
	output logic            intBOe,
	output logic            recoveryStart,
	input  wire logic       recoveryDone,
	output logic            connectA,
	output logic            connectB
);
	typedef enum logic [2:0] {
		M_IDLE    = 3'h1,
		M_RECOVER = 3'h2,
		M_APPLY   = 3'h4
	} dmcs_sw_state_t;

	dmcs_slave_if busA ();
	dmcs_slave_if busB ();

	logic [3:0] addrMeta, addrSync;
	logic [1:0] ownSelect, ownConnect, recoveryRequest, selfIrqTest, peerIrqTest;
	logic [1:0] writtenSinceStop;
	logic       delayedArm;
	logic       applyPending;
	logic       applyChannel;
	logic       reqToggle;
	logic [2:0] reqWord;
	logic       ackMeta, ackSync;
	logic       ctrlWrA, ctrlWrB;
	logic [7:0] viewA, viewB;

	logic       reqMeta, reqSync, reqSeen;
	logic       ackToggle;
	logic [2:0] heldWord;
	logic       intAMeta, intASync, intBMeta, intBSync;
	dmcs_sw_state_t swState;

	// read view of one master's control register; peer bits are never stored here
	function automatic logic [7:0] ctrl_view(input logic peerTest, input logic selfTest,
		input logic recovery, input logic peerConnect, input logic ownCon,
		input logic peerSelect, input logic ownSel);
		logic [7:0] v;
		v = 8'h00;
		v[CTRL_PEER_IRQ_TEST]     = peerTest;
		v[CTRL_SELF_IRQ_TEST]     = selfTest;
		v[CTRL_UNUSED]            = 1'b0;
		v[CTRL_RECOVERY_REQUEST]  = recovery;
		v[CTRL_PEER_CONNECT_COPY] = peerConnect;
		v[CTRL_OWN_CONNECT]       = ownCon;
		v[CTRL_PEER_SELECT_COPY]  = peerSelect;
		v[CTRL_OWN_SELECT]        = ownSel;
		return v;
	endfunction : ctrl_view

	// ************************************************************
	// upstream slave front ends
	// ************************************************************
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			addrMeta <= 4'h0;
			addrSync <= 4'h0;
		end else begin
			addrMeta <= addrPin;
			addrSync <= addrMeta;
		end
	end

	dmcs_i2c_slave u_slave_a (
		.linkClk (linkClk),
		.rst_n   (rst_n),
		.sclIn   (sclA),
		.sdaIn   (sdaAIn),
		.devAddr (addrSync),
		.sdaOut  (sdaAOut),
		.sdaOe   (sdaAOe),
		.bus     (busA.slave)
	);

	dmcs_i2c_slave u_slave_b (
		.linkClk (linkClk),
		.rst_n   (rst_n),
		.sclIn   (sclB),
		.sdaIn   (sdaBIn),
		.devAddr (addrSync),
		.sdaOut  (sdaBOut),
		.sdaOe   (sdaBOe),
		.bus     (busB.slave)
	);

	// ************************************************************
	// control registers (link domain)
	// ************************************************************
	// only pointer 01 reaches control
	assign ctrlWrA = busA.wrStrobe && busA.wrReg == REG_CHANNEL_CONTROL;
	assign ctrlWrB = busB.wrStrobe && busB.wrReg == REG_CHANNEL_CONTROL;

	// peer copies and bit 5 unwritable
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			ownSelect       <= {RESET_SELECT, RESET_SELECT};
			ownConnect      <= {1'b0, VARIANT == VARIANT_CONNECTED};
			recoveryRequest <= {RESET_RECOVERY, RESET_RECOVERY};
			selfIrqTest     <= {RESET_TEST, RESET_TEST};
			peerIrqTest     <= {RESET_TEST, RESET_TEST};
		end else begin
			if (ctrlWrA) begin
				ownSelect[0]       <= busA.wrData[CTRL_OWN_SELECT];
				ownConnect[0]      <= busA.wrData[CTRL_OWN_CONNECT];
				recoveryRequest[0] <= busA.wrData[CTRL_RECOVERY_REQUEST];
				selfIrqTest[0]     <= busA.wrData[CTRL_SELF_IRQ_TEST];
				peerIrqTest[0]     <= busA.wrData[CTRL_PEER_IRQ_TEST];
			end else if (delayedArm && busA.stopSeen) begin
				ownConnect[0] <= 1'b1;
			end
			if (ctrlWrB) begin
				ownSelect[1]       <= busB.wrData[CTRL_OWN_SELECT];
				ownConnect[1]      <= busB.wrData[CTRL_OWN_CONNECT];
				recoveryRequest[1] <= busB.wrData[CTRL_RECOVERY_REQUEST];
				selfIrqTest[1]     <= busB.wrData[CTRL_SELF_IRQ_TEST];
				peerIrqTest[1]     <= busB.wrData[CTRL_PEER_IRQ_TEST];
			end
		end
	end

	// the second master sees the first's select bit inverted, which keeps both
	// views agreeing on one owner: owner = select A xor select B
	// peer select mirror
	assign viewA = ctrl_view(peerIrqTest[0], selfIrqTest[0], recoveryRequest[0],
		ownConnect[1], ownConnect[0], ownSelect[1], ownSelect[0]);
	assign viewB = ctrl_view(peerIrqTest[1], selfIrqTest[1], recoveryRequest[1],
		ownConnect[0], ownConnect[1], ~ownSelect[0], ownSelect[1]);

	// interrupt enable and status live outside this block and read as zero here
	assign busA.rdData = (busA.rdReg == REG_CHANNEL_CONTROL) ? viewA : 8'h00;
	assign busB.rdData = (busB.rdReg == REG_CHANNEL_CONTROL) ? viewB : 8'h00;

	// ************************************************************
	// stop-triggered update request (link domain)
	// ************************************************************
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			ackMeta <= 1'b0;
			ackSync <= 1'b0;
		end else begin
			ackMeta <= ackToggle;
			ackSync <= ackMeta;
		end
	end

	// STOP counts only after own write, or on the first STOP of A in the delayed variant
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			writtenSinceStop <= 2'h0;
			delayedArm       <= (VARIANT == VARIANT_DELAYED);
		end else begin
			if (busA.stopSeen)
				writtenSinceStop[0] <= 1'b0;
			else if (ctrlWrA)
				writtenSinceStop[0] <= 1'b1;
			if (busB.stopSeen)
				writtenSinceStop[1] <= 1'b0;
			else if (ctrlWrB)
				writtenSinceStop[1] <= 1'b1;
			if (busA.stopSeen)
				delayedArm <= 1'b0;
		end
	end

	// one request in flight; a later STOP while busy is merged and uses the
	// registers as they stand at launch, so the last writer still wins
	// last written values decide
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			applyPending <= 1'b0;
			applyChannel <= 1'b0;
			reqToggle    <= 1'b0;
			reqWord      <= 3'h0;
		end else begin
			if (busA.stopSeen && (writtenSinceStop[0] || delayedArm)) begin
				applyPending <= 1'b1;
				applyChannel <= 1'b0;
			end else if (busB.stopSeen && writtenSinceStop[1]) begin
				applyPending <= 1'b1;
				applyChannel <= 1'b1;
			end else if (applyPending && reqToggle == ackSync) begin
				applyPending <= 1'b0;
				reqToggle    <= ~reqToggle;
				reqWord      <= {recoveryRequest[applyChannel], ownSelect[0] ^ ownSelect[1],
					ownConnect[0] ^ ownConnect[1]};
			end
		end
	end

	// ************************************************************
	// switch sequencing (mclk domain)
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reqMeta <= 1'b0;
			reqSync <= 1'b0;
			reqSeen <= 1'b0;
		end else begin
			reqMeta <= reqToggle;
			reqSync <= reqMeta;
			reqSeen <= reqSync;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			swState       <= M_IDLE;
			heldWord      <= 3'h0;
			recoveryStart <= 1'b0;
			ackToggle     <= 1'b0;
			connectA      <= (VARIANT == VARIANT_CONNECTED);
			connectB      <= 1'b0;
		end else begin
			recoveryStart <= 1'b0;
			case (swState)
				M_IDLE: begin
					if (reqSync != reqSeen) begin
						heldWord <= reqWord;
						if (reqWord[2] && reqWord[0]) begin
							recoveryStart <= 1'b1;
							swState       <= M_RECOVER;
						end else begin
							swState <= M_APPLY;
						end
					end
				end
				M_RECOVER: begin
					if (recoveryDone)
						swState <= M_APPLY;
				end
				M_APPLY: begin
					connectA  <= heldWord[0] & ~heldWord[1];
					connectB  <= heldWord[0] & heldWord[1];
					ackToggle <= ~ackToggle;
					swState   <= M_IDLE;
				end
				default: swState <= M_IDLE;
			endcase
		end
	end

	// ************************************************************
	// interrupt wire test (mclk domain)
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			intAMeta <= 1'b0;
			intASync <= 1'b0;
			intBMeta <= 1'b0;
			intBSync <= 1'b0;
		end else begin
			intAMeta <= selfIrqTest[0] | peerIrqTest[1];
			intASync <= intAMeta;
			intBMeta <= selfIrqTest[1] | peerIrqTest[0];
			intBSync <= intBMeta;
		end
	end

	assign intAOut = 1'b0;
	assign intAOe  = intASync;
	assign intBOut = 1'b0;
	assign intBOe  = intBSync;
endmodule : dmcs_channel_select

`default_nettype wire

/* File: rtl/dmcs_i2c_slave.sv */
// upstream i2c slave front end: start/stop, address, pointer, data bytes
// assumes scl/sda arrive from pins and are oversampled by the link clock
`default_nettype none

module dmcs_i2c_slave
	import dmcs_pkg::*;
(
	input  wire logic       linkClk,
	input  wire logic       rst_n,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	input  wire logic [3:0] devAddr,
	output logic            sdaOut,
	output logic            sdaOe,
	dmcs_slave_if.slave     bus
);
	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_ADDR  = 5'h02,
		S_CMD   = 5'h04,
		S_WDATA = 5'h08,
		S_RDATA = 5'h10
	} dmcs_slv_state_t;

	dmcs_slv_state_t state;
	logic            sclMeta, sclSync, sclPrev;
	logic            sdaMeta, sdaSync, sdaPrev;
	logic [7:0]      shift;
	logic [7:0]      rdShift;
	logic [3:0]      bitCnt;
	logic [1:0]      ptr;
	logic            autoInc;
	logic            ackOut;
	logic            outBit;
	logic            sclRise, sclFall, startCond, stopCond, addrMatch;

	// ************************************************************
	// pin synchronisers and bus conditions
	// ************************************************************
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			sclMeta <= 1'b1;
			sclSync <= 1'b1;
			sclPrev <= 1'b1;
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclMeta <= sclIn;
			sclSync <= sclMeta;
			sclPrev <= sclSync;
			sdaMeta <= sdaIn;
			sdaSync <= sdaMeta;
			sdaPrev <= sdaSync;
		end
	end

	assign sclRise   = sclSync & ~sclPrev;
	assign sclFall   = ~sclSync & sclPrev;
	assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
	assign stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;
	assign addrMatch = (shift[7:1] == {I2C_ADDR_PREFIX, devAddr});

	// ************************************************************
	// byte sequencing on rising scl
	// ************************************************************
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= S_IDLE;
			bitCnt  <= 4'h0;
			shift   <= 8'h00;
			ptr     <= 2'h0;
			autoInc <= 1'b0;
		end else if (startCond) begin
			state  <= S_ADDR;
			bitCnt <= 4'h0;
		end else if (stopCond) begin
			state  <= S_IDLE;
			bitCnt <= 4'h0;
		end else if (sclRise && state != S_IDLE) begin
			if (bitCnt != BIT_COUNT_ACK) begin
				shift  <= {shift[6:0], sdaSync};
				bitCnt <= bitCnt + 4'h1;
			end else begin
				bitCnt <= 4'h0;
				case (state)
					S_ADDR: begin
						if (!addrMatch)
							state <= S_IDLE;
						else if (shift[0])
							state <= S_RDATA;
						else
							state <= S_CMD;
					end
					S_CMD: begin
						ptr     <= shift[1:0];
						autoInc <= shift[CMD_AUTO_INCREMENT_BIT];
						state   <= S_WDATA;
					end
					S_WDATA: begin
						if (autoInc)
							ptr <= ptr + 2'h1;
					end
					S_RDATA: begin
						if (sdaSync)
							state <= S_IDLE;
						else if (autoInc)
							ptr <= ptr + 2'h1;
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// write strobe and stop report
	// ************************************************************
	// write lands on ack clock rise
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			bus.wrStrobe <= 1'b0;
			bus.wrReg    <= 2'h0;
			bus.wrData   <= 8'h00;
			bus.stopSeen <= 1'b0;
		end else begin
			bus.wrStrobe <= sclRise && !startCond && !stopCond && state == S_WDATA && bitCnt == BIT_COUNT_ACK;
			bus.wrReg    <= ptr;
			bus.wrData   <= shift;
			bus.stopSeen <= stopCond;
		end
	end

	// ************************************************************
	// sda drive, changed only while scl is low
	// ************************************************************
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			ackOut  <= 1'b0;
			outBit  <= 1'b1;
			rdShift <= 8'h00;
		end else if (startCond || stopCond) begin
			ackOut <= 1'b0;
			outBit <= 1'b1;
		end else if (sclFall) begin
			ackOut <= bitCnt == BIT_COUNT_ACK &&
				((state == S_ADDR && addrMatch) || state == S_CMD || state == S_WDATA);
			if (state != S_RDATA || bitCnt == BIT_COUNT_ACK) begin
				outBit <= 1'b1;
			end else if (bitCnt == 4'h0) begin
				rdShift <= bus.rdData;
				outBit  <= bus.rdData[7];
			end else begin
				outBit <= rdShift[~bitCnt[2:0]];
			end
		end
	end

	assign bus.rdReg = ptr;
	assign sdaOut    = 1'b0;
	assign sdaOe     = ackOut | ~outBit;
endmodule : dmcs_i2c_slave

`default_nettype wire

/* File: rtl/dmcs_pkg.sv */
// constants shared by the dual master channel select block
// assumes a 200 MHz core clock and a free-running link sampling clock
`default_nettype none

package dmcs_pkg;
	// ************************************************************
	// register pointer and command byte
	// ************************************************************
	localparam logic [1:0] REG_IRQ_ENABLE = 2'h0;
	localparam logic [1:0] REG_CHANNEL_CONTROL = 2'h1;
	localparam logic [1:0] REG_IRQ_STATUS = 2'h2;
	localparam int CMD_AUTO_INCREMENT_BIT = 4;
	localparam logic [2:0] I2C_ADDR_PREFIX = 3'h7;
	localparam logic [3:0] BIT_COUNT_ACK = 4'h8;

	// ************************************************************
	// channel_control field positions
	// ************************************************************
	localparam int CTRL_OWN_SELECT = 0;
	localparam int CTRL_PEER_SELECT_COPY = 1;
	localparam int CTRL_OWN_CONNECT = 2;
	localparam int CTRL_PEER_CONNECT_COPY = 3;
	localparam int CTRL_RECOVERY_REQUEST = 4;
	localparam int CTRL_UNUSED = 5;
	localparam int CTRL_SELF_IRQ_TEST = 6;
	localparam int CTRL_PEER_IRQ_TEST = 7;

	// ************************************************************
	// start-up variants and reset values
	// ************************************************************
	localparam logic [1:0] VARIANT_CONNECTED = 2'h0;
	localparam logic [1:0] VARIANT_DELAYED = 2'h1;
	localparam logic [1:0] VARIANT_UNCONNECTED = 2'h2;
	localparam logic RESET_SELECT = 1'b0;
	localparam logic RESET_TEST = 1'b0;
	localparam logic RESET_RECOVERY = 1'b0;

	// ************************************************************
	// clocks
	// ************************************************************
	localparam int MCLK_PERIOD_NS = 5;
	localparam int SYNC_STAGES = 2;
endpackage : dmcs_pkg

`default_nettype wire

/* File: rtl/dmcs_slave_if.sv */
// register access carrier between one upstream slave front end and the core
// assumes both ends run on the link sampling clock
`default_nettype none

interface dmcs_slave_if;
	logic       stopSeen;
	logic       wrStrobe;
	logic [1:0] wrReg;
	logic [7:0] wrData;
	logic [1:0] rdReg;
	logic [7:0] rdData;

	modport slave (
		output stopSeen,
		output wrStrobe,
		output wrReg,
		output wrData,
		output rdReg,
		input  rdData
	);
	modport core (
		input  stopSeen,
		input  wrStrobe,
		input  wrReg,
		input  wrData,
		input  rdReg,
		output rdData
	);
endinterface : dmcs_slave_if

`default_nettype wire

/* File: testbench/dmcs_channel_select_checker.sv */
// pin-level assertions for the dual master channel select block
// assumes a bind from the bench top that hands on VARIANT
`default_nettype none

module dmcs_channel_select_checker
	import dmcs_pkg::*;
#(
	parameter logic [1:0] VARIANT = VARIANT_CONNECTED
) (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       linkClk,
	input wire logic       sclA,
	input wire logic       sdaAIn,
	input wire logic       sdaAOut,
	input wire logic       sdaAOe,
	input wire logic       sclB,
	input wire logic       sdaBIn,
	input wire logic       sdaBOut,
	input wire logic       sdaBOe,
	input wire logic [3:0] addrPin,
	input wire logic       intAOut,
	input wire logic       intAOe,
	input wire logic       intBOut,
	input wire logic       intBOe,
	input wire logic       recoveryStart,
	input wire logic       recoveryDone,
	input wire logic       connectA,
	input wire logic       connectB
);
	timeunit 1ns;
	timeprecision 1ps;
	logic recPending;

	// recovery launched and not yet answered by the far side
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			recPending <= 1'b0;
		end else if (recoveryStart) begin
			recPending <= 1'b1;
		end else if (recoveryDone) begin
			recPending <= 1'b0;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	a_reset_values: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(rst_n) |-> connectA == (VARIANT == VARIANT_CONNECTED) && !connectB && !intAOe && !intBOe)
		else $error("start-up connect or interrupt state wrong");
	a_connect_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
		!(connectA && connectB))
		else $error("both channels joined downstream");
	a_open_drain: assert property (@(posedge mclk) disable iff (!rst_n)
		!sdaAOut && !sdaBOut && !intAOut && !intBOut)
		else $error("open-drain pin drives high");
	a_recovery_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
		recoveryStart |=> !recoveryStart)
		else $error("recovery start longer than one cycle");
	a_hold_during_recovery: assert property (@(posedge mclk) disable iff (!rst_n)
		recPending && !recoveryDone |=> $stable({connectA, connectB}))
		else $error("channel switched before recovery done");
	a_apply_after_recovery: assert property (@(posedge mclk) disable iff (!rst_n)
		recPending && recoveryDone |-> ##[2:3] (connectA ^ connectB))
		else $error("no channel joined after recovery");
	a_sda_a_steady: assert property (@(posedge linkClk) disable iff (!rst_n)
		sclA [*3] |-> $stable(sdaAOe))
		else $error("SDA A moved while SCL high");
	a_sda_b_steady: assert property (@(posedge linkClk) disable iff (!rst_n)
		sclB [*3] |-> $stable(sdaBOe))
		else $error("SDA B moved while SCL high");
	a_start_no_recovery: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(rst_n) |-> !recoveryStart && !sdaAOe && !sdaBOe)
		else $error("activity right after reset");
endmodule : dmcs_channel_select_checker

`default_nettype wire

/* File: testbench/dmcs_i2c_master_model.sv */
// behavioural upstream bus master for one channel
// assumes open-drain lines resolved by the bench with pull-ups
`default_nettype none

module dmcs_i2c_master_model (
	input  wire logic mclk,
	input  wire logic sdaLine,
	output logic      scl,
	output logic      sdaLow
);
	timeunit 1ns;
	timeprecision 1ps;
	// half bit in mclk; keeps each SCL phase above three link clock periods
	localparam int H = 32;

	// ************************************************************
	// bus cycles
	// ************************************************************
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge mclk);
	endtask : hw
	task automatic start;
		sdaLow = 1'b1;
		hw(H);
		scl = 1'b0;
		hw(8);
	endtask : start
	task automatic stop;
		sdaLow = 1'b1;
		hw(H);
		scl = 1'b1;
		hw(H);
		sdaLow = 1'b0;
		hw(H);
	endtask : stop
	// data changes only well after SCL falls
	task automatic bit_io(input logic b, output logic r);
		sdaLow = !b;
		hw(H);
		scl = 1'b1;
		hw(H / 2);
		r = sdaLine;
		hw(H / 2);
		scl = 1'b0;
		hw(8);
	endtask : bit_io
	task automatic xfer(input logic [7:0] tx, input logic mAck, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(!mAck, r);
		ack = !r;
	endtask : xfer
	task automatic write_regs(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] d0,
			input logic [7:0] d1, input int n, input logic doStop, output logic adrAck);
		logic [7:0] rx;
		logic       a;
		start();
		xfer(adr, 1'b0, rx, adrAck);
		if (adrAck) begin
			xfer(cmd, 1'b0, rx, a);
			if (n > 0) xfer(d0, 1'b0, rx, a);
			if (n > 1) xfer(d1, 1'b0, rx, a);
		end
		if (doStop) stop();
	endtask : write_regs
	task automatic read_reg(input logic [7:0] adr, input logic [7:0] cmd, output logic [7:0] v);
		logic a;
		write_regs(adr, cmd, 8'h00, 8'h00, 0, 1'b1, a);
		start();
		xfer(adr | 8'h01, 1'b0, v, a);
		// a single byte, closed by a master not-acknowledge
		xfer(8'hff, 1'b0, v, a);
		stop();
	endtask : read_reg
endmodule : dmcs_i2c_master_model

`default_nettype wire

/* File: testbench/dual_master_channel_select_tb_top.sv */
// self-checking bench: two bus master models and a recovery responder
// assumes the design in its start-up connected variant
`default_nettype none

module dual_master_channel_select_tb_top
	import dmcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ADR = {I2C_ADDR_PREFIX, 4'h5, 1'b0};
	logic        mclk, linkClk, rst_n, recoveryDone, sclA, sclB, lowA, lowB, sdaA, sdaB;
	logic        sdaAOe, sdaBOe, intAOe, intBOe, recoveryStart, connectA, connectB, ack, m;
	logic        selA, selB, conA, conB, recA, recB, tA, tB, pA, pB, eConA, eConB, dConA, dConB;
	logic [7:0]  d, v;
	logic [15:0] rnd;
	int          errors = 0, checked = 0, cycles = 0, recSeen = 0, recExp = 0, recWait = 0;

	assign sdaA = ~(lowA | sdaAOe);
	assign sdaB = ~(lowB | sdaBOe);
	dmcs_channel_select u_dut (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk), .sclA(sclA), .sdaAIn(sdaA),
		.sdaAOut(), .sdaAOe(sdaAOe), .sclB(sclB), .sdaBIn(sdaB), .sdaBOut(), .sdaBOe(sdaBOe),
		.addrPin(4'h5), .intAOut(), .intAOe(intAOe), .intBOut(), .intBOe(intBOe),
		.recoveryStart(recoveryStart), .recoveryDone(recoveryDone), .connectA(connectA), .connectB(connectB));
	// delayed start-up copy at an address nobody calls; it only reacts to STOPs on channel A
	dmcs_channel_select #(.VARIANT(VARIANT_DELAYED)) u_dut_delayed (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk),
		.sclA(sclA), .sdaAIn(sdaA), .sdaAOut(), .sdaAOe(), .sclB(sclB), .sdaBIn(sdaB), .sdaBOut(), .sdaBOe(),
		.addrPin(4'h7), .intAOut(), .intAOe(), .intBOut(), .intBOe(), .recoveryStart(), .recoveryDone(1'b0),
		.connectA(dConA), .connectB(dConB));
	dmcs_i2c_master_model u_mA (.mclk(mclk), .sdaLine(sdaA), .scl(sclA), .sdaLow(lowA));
	dmcs_i2c_master_model u_mB (.mclk(mclk), .sdaLine(sdaB), .scl(sclB), .sdaLow(lowB));

	// ************************************************************
	// clocks, far-side recovery, timeout
	// ************************************************************
	initial begin
		mclk = 1'b0;
		forever #(MCLK_PERIOD_NS / 2.0) mclk = ~mclk;
	end
	initial begin
		linkClk = 1'b0;
		#7;
		forever #24 linkClk = ~linkClk;
	end
	// recovery answered after a random delay, as a slow bus would
	always @(negedge mclk) begin
		recoveryDone <= 1'b0;
		if (recWait > 0) begin
			recWait <= recWait - 1;
			if (recWait == 1) recoveryDone <= 1'b1;
		end else if (recoveryStart === 1'b1) begin
			recSeen <= recSeen + 1;
			recWait <= 3 + rnd[3:0];
		end
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 95000) begin
			errors++;
			close_out();
		end
	end

	// ************************************************************
	// tasks and expectations
	// ************************************************************
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	function automatic logic [7:0] view(input logic b);
		return b ? {pB, tB, 1'b0, recB, conA, conB, ~selA, selB} : {pA, tA, 1'b0, recA, conB, conA, selB, selA};
	endfunction : view
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask : cmp
	task automatic set_regs(input logic b, input logic [7:0] x);
		if (b) {pB, tB, recB, conB, selB} = {x[7:6], x[4], x[2], x[0]};
		else {pA, tA, recA, conA, selA} = {x[7:6], x[4], x[2], x[0]};
	endtask : set_regs
	task automatic apply_stop(input logic b);
		if ((conA ^ conB) && (b ? recB : recA)) recExp++;
		eConA = (conA ^ conB) & ~(selA ^ selB);
		eConB = (conA ^ conB) & (selA ^ selB);
	endtask : apply_stop
	task automatic rd(input logic b, input logic [7:0] cmd, output logic [7:0] x);
		if (b) u_mB.read_reg(ADR, cmd, x);
		else u_mA.read_reg(ADR, cmd, x);
	endtask : rd
	task automatic check_all;
		logic [7:0] x;
		for (int i = 0; i < 2; i++) begin
			rd(i[0], 8'h01, x);
			cmp("view", view(i[0]), x);
		end
		cmp("connect", {6'h0, eConA, eConB}, {6'h0, connectA, connectB});
		cmp("intOe", {6'h0, tA | pB, tB | pA}, {6'h0, intAOe, intBOe});
		cmp("recovery", recExp[7:0], recSeen[7:0]);
	endtask : check_all
	task automatic close_out;
		if (errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rst_n = 1'b0;
		rnd = 16'ha02d;
		{pA, tA, recA, selA, pB, tB, recB, conB, eConB} = '0;
		{conA, eConA, selB} = 3'b110;
		repeat (20) @(posedge mclk);
		@(negedge mclk) rst_n = 1'b1;
		repeat (40) @(negedge mclk);
		check_all();
		cmp("delayedConnect", 8'h02, {6'h0, dConA, dConB});
		rd(1'b0, 8'h00, v);
		cmp("pointer0", 8'h00, v);
		u_mB.write_regs(ADR ^ 8'h02, 8'h01, 8'hff, 8'h00, 1, 1'b1, ack);
		cmp("foreignAck", 8'h00, {7'h0, ack});
		// a STOP on the other channel must leave the connection alone
		u_mB.write_regs(ADR, 8'h01, 8'h25, 8'h00, 1, 1'b0, ack);
		set_regs(1'b1, 8'h25);
		rd(1'b0, 8'h01, v);
		cmp("viewBeforeStop", view(1'b0), v);
		cmp("noSwitch", {6'h0, eConA, eConB}, {6'h0, connectA, connectB});
		u_mB.stop();
		apply_stop(1'b1);
		check_all();
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr_next(rnd);
			m = rnd[0];
			d = rnd[15:8];
			rnd = lfsr_next(rnd);
			if (rnd[1] || i == 0) begin
				u_mA.write_regs(ADR, 8'h10, rnd[7:0], d, 2, 1'b1, ack);
				m = 1'b0;
			end else if (m) u_mB.write_regs(ADR, 8'h01, d, 8'h00, 1, 1'b1, ack);
			else u_mA.write_regs(ADR, 8'h01, d, 8'h00, 1, 1'b1, ack);
			set_regs(m, d);
			apply_stop(m);
			check_all();
		end
		close_out();
	end
endmodule : dual_master_channel_select_tb_top

bind dmcs_channel_select dmcs_channel_select_checker #(.VARIANT(VARIANT)) u_chk (.mclk(mclk), .rst_n(rst_n),
	.linkClk(linkClk), .sclA(sclA), .sdaAIn(sdaAIn), .sdaAOut(sdaAOut), .sdaAOe(sdaAOe), .sclB(sclB),
	.sdaBIn(sdaBIn), .sdaBOut(sdaBOut), .sdaBOe(sdaBOe), .addrPin(addrPin), .intAOut(intAOut), .intAOe(intAOe),
	.intBOut(intBOut), .intBOe(intBOe), .recoveryStart(recoveryStart), .recoveryDone(recoveryDone),
	.connectA(connectA), .connectB(connectB));

`default_nettype wire
